/* rtl/pll_cfg_pkg.sv */
// package: configuration layout, constants and types for the pll clock config block
//
// Behaviour
// [RQ1] feedback value is 12 bits, reference value 10 bits, from nonvolatile rows
// [RQ2] pll frequency = ref * 2 * (feedback + 5) / (reference + 2)
// [RQ3] hold feedback, reference, divider, tuning, duty level, power mode, timing
// [RQ4] tuning enables eleven load capacitors per inverter side; more load lowers frequency
// [RQ5] power-down mode: low control pin stops circuitry, output tri-stated, pulled low
// [RQ6] after power-down, wait for oscillator and pll relock before output resumes
// [RQ7] output-enable mode: low pin tri-states output while oscillator and pll run
// [RQ8] asynchronous timing disables output immediately at any clock phase
// [RQ9] synchronous timing waits for the next output falling edge before disabling
// [RQ10] output re-enables only at the next output falling edge after deassertion
// [RQ11] shadow copy is active until the valid bit is set, then programmed row
// [RQ12] shadow copy accepts repeated rewrites; programmer burns row only when done
// [RQ13] build option disables shadow copy; programmed configuration always active
// [RQ14] select variant: pin picks row 0 or row 1, no power management
// [RQ15] programming mode: control pin is supply input, clock output is tri-state input
// [RQ16] output divider ratios 1,2,4,8,16,32,64,128
// [RQ17] divider source is pll or crystal directly, sixteen options
// [RQ18] control pin has pull-up; undriven pin keeps device running and output on
// [RQ19] control pin is synchronised before falling-edge qualification
package pll_cfg_pkg;

  localparam int FB_W      = 12;
  localparam int REF_W     = 10;
  localparam int DIV_SEL_W = 3;
  localparam int TUNE_N    = 11;
  localparam int FB_OFFSET  = 5;
  localparam int REF_OFFSET = 2;
  localparam int MULT_W     = FB_W + 2;

  // relock wait, in microseconds, and its cycle count at 100 MHz
  localparam int RELOCK_US    = 100;
  localparam int CLK_MHZ      = 100;
  localparam int RELOCK_CYCLES = RELOCK_US * CLK_MHZ;

  // variants
  typedef enum logic [1:0] {
    VAR_SHADOW   = 2'b00,
    VAR_NOSHADOW = 2'b01,
    VAR_FREQSEL  = 2'b10
  } variant_t;

  typedef struct packed {
    logic [FB_W-1:0]      feedback;
    logic [REF_W-1:0]     reference;
    logic [DIV_SEL_W-1:0] div_sel;
    logic                 div_from_xtal;
    logic [TUNE_N-1:0]    tune_gate;
    logic [TUNE_N-1:0]    tune_drain;
    logic                 duty_cmos;
    logic                 pm_output_enable;
    logic                 pm_sync;
  } cfg_row_t;

  localparam cfg_row_t CFG_RESET = '0;

  typedef enum logic [1:0] {
    OUT_RUN     = 2'b00,
    OUT_OFF     = 2'b01,
    OUT_RELOCK  = 2'b11
  } out_state_t;

endpackage

/* rtl/out_divider.sv */
// module: power-of-two output divider on the chosen source clock
`timescale 1ns/1ps
`default_nettype none
module out_divider
  import pll_cfg_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 src_pll,
  input  wire logic                 src_xtal,
  input  wire logic                 from_xtal,
  input  wire logic [DIV_SEL_W-1:0] div_sel,
  output logic                      div_out
);

  logic       src;
  logic       src_q;
  logic [6:0] count;

  assign src = from_xtal ? src_xtal : src_pll; // [RQ17]

  // count source rising edges; ratio 2^div_sel
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_q <= 1'b0;
      count <= 7'h00;
    end else begin
      src_q <= src;
      if (src && !src_q) begin
        count <= count + 7'h01;
      end
    end
  end

  // select tap; ratio 1 passes the registered source
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_out <= 1'b0;
    end else if (div_sel == 3'h0) begin
      div_out <= src_q; // [RQ16]
    end else begin
      div_out <= count[div_sel - 3'h1]; // [RQ16]
    end
  end

endmodule
`default_nettype wire

/* rtl/pll_clock_config_power_control.sv */
// module: configuration selection and output power control for the pll clock die
`timescale 1ns/1ps
`default_nettype none
module pll_clock_config_power_control
  import pll_cfg_pkg::*;
#(
  parameter variant_t VARIANT      = VAR_SHADOW,
  parameter int       RELOCK_COUNT = RELOCK_CYCLES
) (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire cfg_row_t            row0,
  input  wire cfg_row_t            row1,
  input  wire logic                row0_valid,
  input  wire cfg_row_t            shadow_wdata,
  input  wire logic                shadow_we,
  input  wire logic                program_mode,
  input  wire logic                power_down_n,
  input  wire logic                pll_clk,
  input  wire logic                xtal_clk,
  input  wire logic                pll_locked,
  input  wire logic                clock_output_in,
  output logic                     clock_output,
  output logic                     clock_output_oe,
  output logic                     clock_output_pulldown,
  output logic                     osc_pll_enable,
  output logic [FB_W-1:0]          pll_feedback,
  output logic [REF_W-1:0]         pll_reference,
  output logic [MULT_W-1:0]        pll_mult,
  output logic [REF_W:0]           pll_div,
  output logic [TUNE_N-1:0]        tune_gate,
  output logic [TUNE_N-1:0]        tune_drain,
  output logic                     duty_cmos,
  output logic                     prog_data_in
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta;
  logic rst_n;

  // async assert, two-flop release
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shadow copy and active configuration
  cfg_row_t shadow;
  cfg_row_t active;
  logic     shadow_loaded;

  // shadow follows row 0 until written; rewrites allowed any number of times
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shadow        <= CFG_RESET;
      shadow_loaded <= 1'b0;
    end else if (shadow_we) begin
      shadow        <= shadow_wdata; // [RQ12]
      shadow_loaded <= 1'b1;
    end else if (!shadow_loaded) begin
      shadow <= row0;
    end
  end

  // select row by variant, valid bit and select pin
  always_comb begin
    case (VARIANT)
      VAR_NOSHADOW: active = row0; // [RQ13]
      VAR_FREQSEL:  active = power_down_n ? row1 : row0; // [RQ14]
      default:      active = row0_valid ? row0 : shadow; // [RQ11]
    endcase
  end

  // registered configuration outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pll_feedback  <= '0;
      pll_reference <= '0;
      pll_mult      <= '0;
      pll_div       <= '0;
      tune_gate     <= '0;
      tune_drain    <= '0;
      duty_cmos     <= 1'b0;
    end else begin
      pll_feedback  <= active.feedback; // [RQ1] [RQ3]
      pll_reference <= active.reference; // [RQ1]
      // multiplier 2*(p+5), divider q+2
      pll_mult      <= MULT_W'((MULT_W'(active.feedback) + MULT_W'(FB_OFFSET)) << 1); // [RQ2]
      pll_div       <= (REF_W+1)'(active.reference) + (REF_W+1)'(REF_OFFSET); // [RQ2]
      tune_gate     <= active.tune_gate; // [RQ4]
      tune_drain    <= active.tune_drain; // [RQ4]
      duty_cmos     <= active.duty_cmos; // [RQ3]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output divider
  logic div_clk;

  out_divider u_div (
    .clk       (clk),
    .rst_n     (rst_n),
    .src_pll   (pll_clk),
    .src_xtal  (xtal_clk),
    .from_xtal (active.div_from_xtal),
    .div_sel   (active.div_sel),
    .div_out   (div_clk)
  );

  ////////////////////////////////////////////////////////////////////////////
  // control pin synchroniser and falling edge of output
  logic ctl_meta;
  logic ctl_sync;
  logic div_q;
  logic fall;
  logic pm_active;

  // pin reads high when undriven (pull-up outside); select variant has no power control
  assign pm_active = (VARIANT != VAR_FREQSEL) && !program_mode; // [RQ18]

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_meta <= 1'b1;
      ctl_sync <= 1'b1;
      div_q    <= 1'b0;
    end else begin
      ctl_meta <= power_down_n; // [RQ19]
      ctl_sync <= ctl_meta; // [RQ19]
      div_q    <= div_clk;
    end
  end

  assign fall = div_q && !div_clk;

  ////////////////////////////////////////////////////////////////////////////
  // output state machine
  out_state_t state;
  out_state_t next_state;
  logic [$clog2(RELOCK_COUNT+1)-1:0] relock_cnt;
  logic disable_req;

  // async mode reacts to the raw pin: only logic delay, any phase
  assign disable_req = active.pm_sync ? !ctl_sync : (!ctl_sync || !power_down_n); // [RQ8]

  always_comb begin
    next_state = state;
    case (state)
      OUT_RUN: begin
        if (pm_active && disable_req && (!active.pm_sync || fall)) begin
          next_state = OUT_OFF; // [RQ9]
        end
      end
      OUT_OFF: begin
        if (!pm_active) begin
          next_state = OUT_RUN;
        end else if (ctl_sync && power_down_n) begin
          next_state = active.pm_output_enable ? OUT_RUN : OUT_RELOCK; // [RQ7] [RQ6]
        end
      end
      OUT_RELOCK: begin
        if (pm_active && !ctl_sync) begin
          next_state = OUT_OFF;
        end else if (relock_cnt == '0 && pll_locked) begin
          next_state = OUT_RUN; // [RQ6]
        end
      end
      default: next_state = OUT_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= OUT_RUN;
    end else begin
      state <= next_state;
    end
  end

  // relock timer loads on entry
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      relock_cnt <= '0;
    end else if (state != OUT_RELOCK) begin
      relock_cnt <= ($clog2(RELOCK_COUNT+1))'(RELOCK_COUNT); // [RQ6]
    end else if (relock_cnt != '0) begin
      relock_cnt <= relock_cnt - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output drive; re-enable lines up with an output falling edge
  logic drive;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drive <= 1'b0;
    end else if (program_mode) begin
      drive <= 1'b0; // [RQ15]
    end else if (state != OUT_RUN) begin
      drive <= 1'b0; // [RQ5] [RQ7]
    end else if (!drive && fall) begin
      drive <= 1'b1; // [RQ10]
    end
  end

  // async disable cuts the drive combinationally
  assign clock_output_oe = drive && !(pm_active && !active.pm_sync && !power_down_n); // [RQ8]
  assign clock_output_pulldown = !clock_output_oe; // [RQ5]

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clock_output   <= 1'b0;
      osc_pll_enable <= 1'b1;
      prog_data_in   <= 1'b0;
    end else begin
      clock_output   <= div_clk;
      // power-down stops oscillator and pll; output-enable keeps them on
      osc_pll_enable <= !(state == OUT_OFF && !active.pm_output_enable); // [RQ5] [RQ7]
      prog_data_in   <= program_mode ? clock_output_in : 1'b0; // [RQ15]
    end
  end

endmodule
`default_nettype wire

/* verif/pll_cfg_asserts.sv */
// concurrent checks on the ports of the pll clock config block
`timescale 1ns/1ps
`default_nettype none
module pll_cfg_asserts
  import pll_cfg_pkg::*;
#(
  parameter variant_t VARIANT = VAR_SHADOW
) (
  input wire logic              clk,
  input wire logic              reset_n,
  input wire cfg_row_t          row0,
  input wire logic              row0_valid,
  input wire logic              program_mode,
  input wire logic              power_down_n,
  input wire logic              clock_output,
  input wire logic              clock_output_oe,
  input wire logic              clock_output_pulldown,
  input wire logic              osc_pll_enable,
  input wire logic [FB_W-1:0]   pll_feedback,
  input wire logic [REF_W-1:0]  pll_reference,
  input wire logic [MULT_W-1:0] pll_mult,
  input wire logic [REF_W:0]    pll_div
);
  logic [2:0] age;
  logic       row_on;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////
  // internal reset lags two edges, so early cycles are skipped
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) age <= 3'h0;
    else if (age != 3'h7) age <= age + 3'h1;
  end
  // programmed row drives the outputs only with power control live
  assign row_on = (VARIANT != VAR_FREQSEL) && row0_valid && !program_mode;
  sequence s_reenable;
    !clock_output_oe ##1 clock_output_oe;
  endsequence
  AST_PULLDOWN: assert property (clock_output_pulldown == !clock_output_oe)
    else $error("pull-down not inverse of drive");
  AST_ARITH: assert property (age == 3'h7 |->
    int'(pll_mult) == 2 * (int'(pll_feedback) + 5) && int'(pll_div) == int'(pll_reference) + 2)
    else $error("pll ratio wrong");
  AST_PROG: assert property (program_mode [*2] |-> !clock_output_oe)
    else $error("output driven while programming");
  AST_ASYNC: assert property (
    row_on && !row0.pm_sync && !power_down_n |-> !clock_output_oe)
    else $error("async disable late");
  AST_SYNC: assert property (
    row_on && row0.pm_sync && $fell(clock_output_oe) |-> !clock_output)
    else $error("sync disable cut a pulse");
  AST_REEN: assert property (s_reenable |-> !clock_output)
    else $error("enable not at falling edge");
  AST_CFG: assert property (
    (age == 3'h7 && row_on && $stable(row0)) [*3] |->
    pll_feedback == row0.feedback && pll_reference == row0.reference)
    else $error("programmed row not applied");
  AST_OSC: assert property (
    (age == 3'h7 && row_on && row0.pm_output_enable && $stable(row0)) [*2] |-> osc_pll_enable)
    else $error("oscillator stopped in enable mode");
endmodule
bind pll_clock_config_power_control pll_cfg_asserts #(.VARIANT(VARIANT)) pll_cfg_asserts_inst (
  .clk(clk), .reset_n(reset_n), .row0(row0), .row0_valid(row0_valid),
  .program_mode(program_mode), .power_down_n(power_down_n), .clock_output(clock_output),
  .clock_output_oe(clock_output_oe), .clock_output_pulldown(clock_output_pulldown),
  .osc_pll_enable(osc_pll_enable), .pll_feedback(pll_feedback),
  .pll_reference(pll_reference), .pll_mult(pll_mult), .pll_div(pll_div));
`default_nettype wire

/* verif/clk_line_model.sv */
// receiving side of the clock line, also the programmer driving it
`timescale 1ns/1ps
`default_nettype none
module clk_line_model (
  input wire logic clk,
  input wire logic program_mode,
  input wire logic clock_output,
  input wire logic clock_output_oe,
  input wire logic clock_output_pulldown,
  output logic     line
);
  logic prog_bit;
  // toggling pattern so a stuck sampler cannot pass
  always_ff @(posedge clk) prog_bit <= (prog_bit === 1'b1) ? 1'b0 : 1'b1;
  // weak pull-down wins only when nobody drives the line
  assign line = clock_output_oe ? clock_output : program_mode ? prog_bit :
                clock_output_pulldown ? 1'b0 : !prog_bit;
endmodule
`default_nettype wire

/* verif/pll_clock_config_power_control_tb_top.sv */
// self-checking bench for the pll clock config block
`timescale 1ns/1ps
`default_nettype none
module pll_clock_config_power_control_tb_top;
  import pll_cfg_pkg::*;
  logic              clk = 1'b0;
  logic              reset_n = 1'b0;
  cfg_row_t          row0, row1, shadow_wdata, r;
  logic              row0_valid, shadow_we, program_mode, power_down_n, b;
  logic              pll_clk, xtal_clk, pll_locked, line, prog_data_in, duty_cmos;
  logic              clock_output, clock_output_oe, clock_output_pulldown, osc_pll_enable;
  logic [FB_W-1:0]   pll_feedback;
  logic [REF_W-1:0]  pll_reference;
  logic [MULT_W-1:0] pll_mult;
  logic [REF_W:0]    pll_div;
  logic [TUNE_N-1:0] tune_gate, tune_drain;
  logic [FB_W-1:0]   alt_fb [2];
  int                num_errors = 0;
  int                comparisons = 0;
  int                cyc = 0;
  int                t0;
  always #5 clk = ~clk;
  pll_clock_config_power_control #(.VARIANT(VAR_SHADOW), .RELOCK_COUNT(4))
    pll_clock_config_power_control_inst (.clk(clk), .reset_n(reset_n), .row0(row0),
    .row1(row1), .row0_valid(row0_valid), .shadow_wdata(shadow_wdata), .shadow_we(shadow_we),
    .program_mode(program_mode), .power_down_n(power_down_n), .pll_clk(pll_clk),
    .xtal_clk(xtal_clk), .pll_locked(pll_locked), .clock_output_in(line),
    .clock_output(clock_output), .clock_output_oe(clock_output_oe),
    .clock_output_pulldown(clock_output_pulldown), .osc_pll_enable(osc_pll_enable),
    .pll_feedback(pll_feedback), .pll_reference(pll_reference), .pll_mult(pll_mult),
    .pll_div(pll_div), .tune_gate(tune_gate), .tune_drain(tune_drain),
    .duty_cmos(duty_cmos), .prog_data_in(prog_data_in));
  clk_line_model clk_line_model_inst (.clk(clk), .program_mode(program_mode),
    .clock_output(clock_output), .clock_output_oe(clock_output_oe),
    .clock_output_pulldown(clock_output_pulldown), .line(line));
  // no-shadow and select builds share the stimulus; only the feedback of their chosen row is compared
  for (genvar g = 0; g < 2; g++) begin : g_alt
    pll_clock_config_power_control #(.VARIANT(variant_t'(g + 1)), .RELOCK_COUNT(4))
      pll_clock_config_power_control_inst (.clk(clk), .reset_n(reset_n), .row0(row0),
      .row1(row1), .row0_valid(row0_valid), .shadow_wdata(shadow_wdata), .shadow_we(shadow_we),
      .program_mode(program_mode), .power_down_n(power_down_n), .pll_clk(pll_clk),
      .xtal_clk(xtal_clk), .pll_locked(pll_locked), .clock_output_in(line),
      .clock_output(), .clock_output_oe(), .clock_output_pulldown(), .osc_pll_enable(),
      .pll_feedback(alt_fb[g]), .pll_reference(), .pll_mult(), .pll_div(), .tune_gate(),
      .tune_drain(), .duty_cmos(), .prog_data_in());
  end
  ////////////////////////////////////////////////////////////////
  // sources: pll period 4 cycles, crystal 6; hang guard on the side
  always @(posedge clk) begin
    cyc <= cyc + 1;
    pll_clk <= cyc[1];
    xtal_clk <= (cyc % 6) < 3;
    if (cyc == 40000) begin
      num_errors++;
      print_verdict;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    if (num_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  function automatic cfg_row_t rnd_row;
    logic [63:0] v;
    v = {$urandom, $urandom};
    rnd_row = v[$bits(cfg_row_t)-1:0];
  endfunction
  // bounded waits; a miss shows up in the following comparison
  task automatic wait_oe(input logic v);
    for (int n = 0; n < 600 && clock_output_oe !== v; n++) @(posedge clk) #1;
  endtask
  task automatic wait_rise;
    for (int n = 0; n < 900 && clock_output !== 1'b0; n++) @(posedge clk) #1;
    for (int n = 0; n < 900 && clock_output !== 1'b1; n++) @(posedge clk) #1;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hc697));
    {row0, row1, shadow_wdata, shadow_we, program_mode} = '0;
    {row0_valid, power_down_n, pll_locked, pll_clk, xtal_clk} = 5'h1e;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    wait_oe(1'b1);
    check(clock_output_oe, 1'b1);
    // random programmed rows, outputs one cycle behind; select build follows row 1
    repeat (20) begin
      @(posedge clk);
      r = rnd_row();
      row0 <= r;
      row1 <= rnd_row();
      repeat (3) @(posedge clk);
      #1 check(pll_feedback, r.feedback);
      check(pll_reference, r.reference);
      check(pll_mult, 32'(2 * (r.feedback + 5)));
      check(pll_div, 32'(r.reference + 2));
      check({tune_gate, tune_drain}, {r.tune_gate, r.tune_drain});
      check(duty_cmos, r.duty_cmos);
      check(alt_fb[1], row1.feedback);
    end
    // shadow copy rewritten twice with the valid bit clear
    @(posedge clk) row0_valid <= 1'b0;
    repeat (2) begin
      @(posedge clk);
      r = rnd_row();
      shadow_wdata <= r;
      shadow_we <= 1'b1;
      @(posedge clk);
      shadow_we <= 1'b0;
      repeat (3) @(posedge clk);
      #1 check({pll_feedback, pll_reference}, {r.feedback, r.reference});
      check(alt_fb[0], row0.feedback);
    end
    // every power mode and timing pairing
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      r = rnd_row();
      {r.div_sel, r.div_from_xtal, r.pm_output_enable, r.pm_sync} = {4'h4, m[0], m[1]};
      row0 <= r;
      row0_valid <= 1'b1;
      repeat (20) @(posedge clk);
      power_down_n <= 1'b0;
      if (!m[1]) #1 check(clock_output_oe, 1'b0);
      wait_oe(1'b0);
      check(clock_output_pulldown, 1'b1);
      repeat (4) @(posedge clk);
      #1 check(osc_pll_enable, m[0]);
      check(alt_fb[1], row0.feedback);
      @(posedge clk);
      pll_locked <= m[0];
      power_down_n <= 1'b1;
      repeat (12) @(posedge clk);
      if (!m[0]) #1 check(clock_output_oe, 1'b0);
      @(posedge clk) pll_locked <= 1'b1;
      wait_oe(1'b1);
      check(clock_output_oe, 1'b1);
    end
    // all sixteen divider options, period measured between rises
    for (int k = 0; k < 16; k++) begin
      @(posedge clk);
      {r.div_from_xtal, r.div_sel} = k[3:0];
      row0 <= r;
      wait_rise();
      wait_rise();
      t0 = cyc;
      wait_rise();
      check(32'(cyc - t0), 32'((k[3] ? 6 : 4) << k[2:0]));
    end
    // programming: line is an input sampled into prog_data_in
    @(posedge clk) program_mode <= 1'b1;
    repeat (3) @(posedge clk);
    repeat (4) begin
      @(negedge clk) b = line;
      @(posedge clk) #1 check(prog_data_in, b);
    end
    check(clock_output_oe, 1'b0);
    print_verdict;
  end
endmodule
`default_nettype wire
